/* hw/pfu_pkg.sv */
// package for the processor flags unit: bit positions, opcodes, carriers
package pfu_pkg;
  localparam int CARRY_BIT = 0;
  localparam int RSV1_BIT = 1;
  localparam int PARITY_BIT = 2;
  localparam int ADJUST_BIT = 4;
  localparam int ZERO_BIT = 6;
  localparam int SIGN_BIT = 7;
  localparam int STEP_BIT = 8;
  localparam int IRQ_EN_BIT = 9;
  localparam int DIR_BIT = 10;
  localparam int OVF_BIT = 11;
  localparam int IO_PRIV_LO = 12;
  localparam int IO_PRIV_HI = 13;
  localparam int NEST_BIT = 14;
  localparam int RESUME_BIT = 16;
  localparam int V86_BIT = 17;
  localparam int ALIGN_BIT = 18;
  localparam int VIRQ_EN_BIT = 19;
  localparam int VIRQ_PEND_BIT = 20;
  localparam int PROBE_BIT = 21;
  // flags word after reset or init: only bit 1 set
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  // bits that hold state; everything else is reserved
  localparam logic [31:0] FLAGS_IMPL = 32'h003f_7fd5;
  // register bus map
  localparam logic [3:0] ADDR_FLAGS_LO = 4'h0;
  localparam logic [3:0] ADDR_FLAGS_HI = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam int CTRL_ALIGN_MASK_BIT = 0;
  localparam int CTRL_VIRQ_EXT_BIT = 1;
  localparam int CTRL_PROBE_SUP_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0007;

  // instruction classes that touch the flags
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SUB_BORROW, OP_LOGIC, OP_SET_CARRY,
    OP_CLR_CARRY, OP_INV_CARRY, OP_BIT_TEST, OP_SET_DIR, OP_CLR_DIR,
    OP_POP_FLAGS, OP_INT_RET, OP_LOAD
  } pfu_op_t;

  // one instruction's flag request
  typedef struct packed {
    logic valid;
    pfu_op_t op;
    logic [1:0] size; // 0:8 1:16 2:32 3:64
    logic [63:0] a;
    logic [63:0] b;
    logic bit_val; // selected bit for bit tests
    logic [31:0] wdata; // image for pop, interrupt_return_instr, task load
  } pfu_req_t;
endpackage : pfu_pkg

/* hw/pfu_flags_unit.sv */
// processor flags unit: status flag generation and flags word storage
//
// Functional notes
// - carry set on carry/borrow out of top
// - parity set for even ones in byte
// - adjust set on carry out of bit3
// - zero set when result is zero
// - sign equals result top bit
// - overflow set on signed range error
// - carry writable: set, clear, invert
// - bit tests copy selected bit to carry
// - add/sub with carry use current carry
// - direction one steps string addresses down
// - direction set and clear instructions
// - trap flag enables single step
// - interrupt flag gates maskable requests
// - io allowed when privilege not above field
// - io field changes by pop/return at level0
// - nested flag follows task link
// - resume flag steers debug exception response
// - v86 flag selects virtual-8086 operation
// - alignment check needs flag and mask
// - virtual flags need extensions enabled
// - probe flag writable when query supported
// - 64-bit word, upper half reserved
// - reset or init loads only bit 1
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module pfu_flags_unit (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic INIT,
  // instruction request from execution
  input wire pfu_pkg::pfu_req_t REQ,
  input wire logic [1:0] PRIV_LEVEL,
  input wire logic LINK_TASK,
  input wire logic UNLINK_TASK,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // flag views for the core
  output logic [63:0] FLAGS_64,
  output logic STRING_DEC,
  output logic SINGLE_STEP,
  output logic IRQ_ACCEPT,
  output logic IO_PERMIT,
  output logic DEBUG_RESUME,
  output logic V86_MODE,
  output logic ALIGN_CHECK,
  output logic VIRT_IRQ_EN,
  output logic VIRT_IRQ_PEND
);
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;
  logic [64:0] res_full;
  logic [63:0] res;
  logic [4:0] nib;
  logic cin;
  logic is_sub;
  logic is_arith;
  logic carry_o;
  logic ovf_o;
  logic zero_o;
  logic sign_o;
  logic [31:0] img;
  logic [31:0] wmask;
  logic [31:0] view_w;

  // width mask for an operand size code
  function automatic logic [63:0] size_mask(input logic [1:0] s);
    case (s)
      2'h0: size_mask = 64'h0000_0000_0000_00ff;
      2'h1: size_mask = 64'h0000_0000_0000_ffff;
      2'h2: size_mask = 64'h0000_0000_ffff_ffff;
      default: size_mask = 64'hffff_ffff_ffff_ffff;
    endcase
  endfunction : size_mask

  // top bit of a value at an operand size
  function automatic logic top_bit(input logic [63:0] v,
                                   input logic [1:0] s);
    case (s)
      2'h0: top_bit = v[7];
      2'h1: top_bit = v[15];
      2'h2: top_bit = v[31];
      default: top_bit = v[63];
    endcase
  endfunction : top_bit

  // carry out of the top bit at an operand size
  function automatic logic carry_at(input logic [64:0] v,
                                    input logic [1:0] s);
    case (s)
      2'h0: carry_at = v[8];
      2'h1: carry_at = v[16];
      2'h2: carry_at = v[32];
      default: carry_at = v[64];
    endcase
  endfunction : carry_at

  // adder for add, adc, sub, sbb on masked operands
  always_comb begin
    logic [63:0] am;
    logic [63:0] bm;
    am = REQ.a & size_mask(REQ.size);
    bm = REQ.b & size_mask(REQ.size);
    is_sub = (REQ.op == pfu_pkg::OP_SUB) ||
             (REQ.op == pfu_pkg::OP_SUB_BORROW);
    is_arith = is_sub || (REQ.op == pfu_pkg::OP_ADD) ||
               (REQ.op == pfu_pkg::OP_ADC);
    cin = 1'b0;
    if ((REQ.op == pfu_pkg::OP_ADC) ||
        (REQ.op == pfu_pkg::OP_SUB_BORROW)) begin
      cin = flags_q[pfu_pkg::CARRY_BIT];
    end
    if (is_sub) begin
      res_full = {1'b0, am} - {1'b0, bm} - {64'h0, cin};
      nib = {1'b0, am[3:0]} - {1'b0, bm[3:0]} - {4'h0, cin};
    end else begin
      res_full = {1'b0, am} + {1'b0, bm} + {64'h0, cin};
      nib = {1'b0, am[3:0]} + {1'b0, bm[3:0]} + {4'h0, cin};
    end
    if (!is_arith) begin
      res_full = {1'b0, am}; // logic ops pass their result in a
      nib = 5'h00;
    end
    res = res_full[63:0] & size_mask(REQ.size);
    carry_o = is_arith && carry_at(res_full, REQ.size);
    zero_o = (res == 64'h0);
    sign_o = top_bit(res, REQ.size);
    // overflow: same-sign inputs (for add) giving other sign
    if (is_sub) begin
      ovf_o = (top_bit(am, REQ.size) != top_bit(bm, REQ.size)) &&
              (top_bit(res, REQ.size) != top_bit(am, REQ.size));
    end else begin
      ovf_o = is_arith &&
              (top_bit(am, REQ.size) == top_bit(bm, REQ.size)) &&
              (top_bit(res, REQ.size) != top_bit(am, REQ.size));
    end
  end

  // which bits a software image may change
  always_comb begin
    img = REQ.wdata;
    wmask = pfu_pkg::FLAGS_IMPL;
    if (PRIV_LEVEL != 2'h0) begin
      wmask[pfu_pkg::IO_PRIV_HI:pfu_pkg::IO_PRIV_LO] = 2'h0;
    end
    if (!ctrl_q[pfu_pkg::CTRL_PROBE_SUP_BIT]) begin
      wmask[pfu_pkg::PROBE_BIT] = 1'b0;
    end
  end

  // next flags word: one instruction commits at a time
  always_comb begin
    flags_d = flags_q;
    if (REQ.valid) begin
      case (REQ.op)
        pfu_pkg::OP_ADD, pfu_pkg::OP_ADC,
        pfu_pkg::OP_SUB, pfu_pkg::OP_SUB_BORROW,
        pfu_pkg::OP_LOGIC: begin
          flags_d[pfu_pkg::CARRY_BIT] = carry_o;
          flags_d[pfu_pkg::PARITY_BIT] = ~^res[7:0];
          flags_d[pfu_pkg::ADJUST_BIT] = nib[4];
          flags_d[pfu_pkg::ZERO_BIT] = zero_o;
          flags_d[pfu_pkg::SIGN_BIT] = sign_o;
          flags_d[pfu_pkg::OVF_BIT] = ovf_o;
        end
        pfu_pkg::OP_SET_CARRY: begin
          flags_d[pfu_pkg::CARRY_BIT] = 1'b1;
        end
        pfu_pkg::OP_CLR_CARRY: begin
          flags_d[pfu_pkg::CARRY_BIT] = 1'b0;
        end
        pfu_pkg::OP_INV_CARRY: begin
          flags_d[pfu_pkg::CARRY_BIT] =
            ~flags_q[pfu_pkg::CARRY_BIT];
        end
        pfu_pkg::OP_BIT_TEST: begin
          flags_d[pfu_pkg::CARRY_BIT] = REQ.bit_val;
        end
        pfu_pkg::OP_SET_DIR: begin
          flags_d[pfu_pkg::DIR_BIT] = 1'b1;
        end
        pfu_pkg::OP_CLR_DIR: begin
          flags_d[pfu_pkg::DIR_BIT] = 1'b0;
        end
        pfu_pkg::OP_POP_FLAGS, pfu_pkg::OP_INT_RET: begin
          flags_d = (flags_q & ~wmask) | (img & wmask);
        end
        pfu_pkg::OP_LOAD: begin
          // task switch image: io field kept unless level 0
          flags_d = (flags_q & ~wmask) | (img & wmask);
        end
        default: begin
          flags_d = flags_q;
        end
      endcase
    end
    if (LINK_TASK) begin
      flags_d[pfu_pkg::NEST_BIT] = 1'b1;
    end else if (UNLINK_TASK) begin
      flags_d[pfu_pkg::NEST_BIT] = 1'b0;
    end
    // reserved bits forced; bit 1 always one
    flags_d = (flags_d & pfu_pkg::FLAGS_IMPL) | pfu_pkg::FLAGS_RESET;
  end

  // flags word register
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_q <= pfu_pkg::FLAGS_RESET;
    end else if (INIT) begin
      flags_q <= pfu_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // control register: align mask, virtual extensions, query support
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= pfu_pkg::CTRL_RESET;
    end else if (WR && (ADDR == pfu_pkg::ADDR_CTRL)) begin
      ctrl_q <= WDATA & pfu_pkg::CTRL_MASK;
    end
  end

  // read port: data in the cycle after the strobe
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0;
    end else if (RD) begin
      case (ADDR)
        pfu_pkg::ADDR_FLAGS_LO: rdata_q <= flags_q;
        pfu_pkg::ADDR_FLAGS_HI: rdata_q <= 32'h0;
        pfu_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
        default: rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  // word the views follow: init shows the reset word at once
  assign view_w = INIT ? pfu_pkg::FLAGS_RESET : flags_d;

  // flag views, registered from view_w (flags_d, or the reset word during init), in step with the committed word
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FLAGS_64 <= {32'h0, pfu_pkg::FLAGS_RESET};
      STRING_DEC <= 1'b0;
      SINGLE_STEP <= 1'b0;
      IRQ_ACCEPT <= 1'b0;
      IO_PERMIT <= 1'b0;
      DEBUG_RESUME <= 1'b0;
      V86_MODE <= 1'b0;
      ALIGN_CHECK <= 1'b0;
      VIRT_IRQ_EN <= 1'b0;
      VIRT_IRQ_PEND <= 1'b0;
    end else begin
      FLAGS_64 <= {32'h0, view_w};
      STRING_DEC <= view_w[pfu_pkg::DIR_BIT];
      SINGLE_STEP <= view_w[pfu_pkg::STEP_BIT];
      IRQ_ACCEPT <= view_w[pfu_pkg::IRQ_EN_BIT];
      IO_PERMIT <= (PRIV_LEVEL <=
                    view_w[pfu_pkg::IO_PRIV_HI:pfu_pkg::IO_PRIV_LO]);
      DEBUG_RESUME <= view_w[pfu_pkg::RESUME_BIT];
      V86_MODE <= view_w[pfu_pkg::V86_BIT];
      ALIGN_CHECK <= view_w[pfu_pkg::ALIGN_BIT] &&
                     ctrl_q[pfu_pkg::CTRL_ALIGN_MASK_BIT];
      VIRT_IRQ_EN <= view_w[pfu_pkg::VIRQ_EN_BIT] &&
                     ctrl_q[pfu_pkg::CTRL_VIRQ_EXT_BIT];
      VIRT_IRQ_PEND <= view_w[pfu_pkg::VIRQ_PEND_BIT] &&
                       ctrl_q[pfu_pkg::CTRL_VIRQ_EXT_BIT];
    end
  end

  assign RDATA = rdata_q;

  // bit 1 always set, reserved always clear
  property p_reserved;
    @(posedge REF_CLK) disable iff (!RST_N)
      (flags_q & ~pfu_pkg::FLAGS_IMPL) == pfu_pkg::FLAGS_RESET;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved flag bits wrong");

  // init gives the reset word next cycle
  property p_init;
    @(posedge REF_CLK) disable iff (!RST_N)
      INIT |=> flags_q == pfu_pkg::FLAGS_RESET;
  endproperty
  a_init: assert property (p_init)
    else $error("init did not load reset word");

  // set carry instruction
  property p_set_carry;
    @(posedge REF_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.op == pfu_pkg::OP_SET_CARRY && !INIT)
        |=> flags_q[pfu_pkg::CARRY_BIT];
  endproperty
  a_set_carry: assert property (p_set_carry)
    else $error("carry not set");

  // complement carry
  property p_inv_carry;
    @(posedge REF_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.op == pfu_pkg::OP_INV_CARRY && !INIT)
        |=> flags_q[pfu_pkg::CARRY_BIT] !=
            $past(flags_q[pfu_pkg::CARRY_BIT]);
  endproperty
  a_inv_carry: assert property (p_inv_carry)
    else $error("carry not inverted");

  // io field held away from level 0
  property p_io_field;
    @(posedge REF_CLK) disable iff (!RST_N)
      (PRIV_LEVEL != 2'h0 && !INIT)
        |=> $stable(flags_q[pfu_pkg::IO_PRIV_HI:pfu_pkg::IO_PRIV_LO]);
  endproperty
  a_io_field: assert property (p_io_field)
    else $error("io field changed at nonzero level");

  // zero flag from an add of two zeros
  property p_zero;
    @(posedge REF_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.op == pfu_pkg::OP_ADD && !INIT &&
       (REQ.a & size_mask(REQ.size)) == 64'h0 &&
       (REQ.b & size_mask(REQ.size)) == 64'h0)
        |=> flags_q[pfu_pkg::ZERO_BIT] && flags_q[pfu_pkg::PARITY_BIT];
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero or parity flag wrong");

  // alignment output needs both enables
  property p_align;
    @(posedge REF_CLK) disable iff (!RST_N)
      ALIGN_CHECK |-> $past(ctrl_q[pfu_pkg::CTRL_ALIGN_MASK_BIT]) &&
                      flags_q[pfu_pkg::ALIGN_BIT];
  endproperty
  a_align: assert property (p_align)
    else $error("alignment check without both enables");

  // io permission tracks level against field
  property p_io;
    @(posedge REF_CLK) disable iff (!RST_N)
      IO_PERMIT |-> $past(PRIV_LEVEL) <=
                    flags_q[pfu_pkg::IO_PRIV_HI:pfu_pkg::IO_PRIV_LO];
  endproperty
  a_io: assert property (p_io)
    else $error("io permitted above field");

  // upper half stays zero
  property p_upper;
    @(posedge REF_CLK) disable iff (!RST_N)
      FLAGS_64[63:32] == 32'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper flags half not zero");
endmodule : pfu_flags_unit

/* test/pfu_exec_model.sv */
// execution-side model: packs one instruction request
`timescale 1ns/1ps
module pfu_exec_model (
  // instruction fields
  input wire logic issue,
  input wire pfu_pkg::pfu_op_t op,
  input wire logic [1:0] size,
  input wire logic [63:0] a,
  input wire logic [63:0] b,
  input wire logic bit_val,
  input wire logic [31:0] img,
  // request toward the flags unit
  output pfu_pkg::pfu_req_t req
);
  // idle slots carry inverted operands, never stale ones
  always_comb begin
    req.valid = issue;
    req.op = issue ? op : pfu_pkg::OP_NONE;
    req.size = size;
    req.a = issue ? a : ~a;
    req.b = issue ? b : ~b;
    req.bit_val = bit_val;
    req.wdata = img; // software owns the pending bit
  end
endmodule : pfu_exec_model

/* test/tb_top.sv */
// self-checking bench for the processor flags unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic ref_clk, rst_n, init, link_task, unlink_task, wr, rd, issue, bit_val;
  logic [1:0] priv_lvl, size;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, img, ef, ctrl_m, e, rs;
  logic [63:0] a, b, flags_64;
  logic string_dec, single_step, irq_accept, io_permit, debug_resume;
  logic v86_mode, align_check, virt_irq_en, virt_irq_pend, rd_p, iv_p;
  pfu_pkg::pfu_op_t op;
  pfu_pkg::pfu_req_t req;
  logic [31:0] rq[$];
  logic [31:0] fq[$];
  int err_count = 0;
  int samples_checked = 0;
  integer seed = 32'ha0b51f7b;
  pfu_pkg::pfu_op_t cops[8] = '{pfu_pkg::OP_SET_CARRY,
    pfu_pkg::OP_INV_CARRY, pfu_pkg::OP_CLR_CARRY, pfu_pkg::OP_INV_CARRY,
    pfu_pkg::OP_BIT_TEST, pfu_pkg::OP_BIT_TEST, pfu_pkg::OP_SET_DIR,
    pfu_pkg::OP_CLR_DIR};
  pfu_pkg::pfu_op_t aops[8] = '{pfu_pkg::OP_ADD, pfu_pkg::OP_ADC,
    pfu_pkg::OP_SUB, pfu_pkg::OP_SUB_BORROW, pfu_pkg::OP_LOGIC,
    pfu_pkg::OP_ADD, pfu_pkg::OP_SUB, pfu_pkg::OP_SUB_BORROW};

  pfu_exec_model pfu_exec_model_inst (.issue(issue), .op(op), .size(size),
    .a(a), .b(b), .bit_val(bit_val), .img(img), .req(req));
  pfu_flags_unit pfu_flags_unit_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
    .INIT(init), .REQ(req), .PRIV_LEVEL(priv_lvl), .LINK_TASK(link_task),
    .UNLINK_TASK(unlink_task), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .FLAGS_64(flags_64), .STRING_DEC(string_dec),
    .SINGLE_STEP(single_step), .IRQ_ACCEPT(irq_accept),
    .IO_PERMIT(io_permit), .DEBUG_RESUME(debug_resume), .V86_MODE(v86_mode),
    .ALIGN_CHECK(align_check), .VIRT_IRQ_EN(virt_irq_en),
    .VIRT_IRQ_PEND(virt_irq_pend));

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // reference flags after one instruction
  function automatic logic [31:0] nxt(input logic [31:0] f,
      input pfu_pkg::pfu_op_t o, input logic [1:0] s,
      input logic [63:0] x, y, input logic bv, input logic [31:0] w);
    logic [64:0] m, r;
    logic [31:0] wm;
    int n;
    logic sb, ci;
    n = 8 << s;
    m = (65'h1 << n) - 65'h1;
    sb = (o == pfu_pkg::OP_SUB) || (o == pfu_pkg::OP_SUB_BORROW);
    ci = f[0] && (o == pfu_pkg::OP_ADC ||
      o == pfu_pkg::OP_SUB_BORROW);
    r = {1'b0, x} & m;
    nxt = f;
    if (o inside {pfu_pkg::OP_ADD, pfu_pkg::OP_ADC, pfu_pkg::OP_SUB,
      pfu_pkg::OP_SUB_BORROW}) begin
      r = sb ? (x & m) - (y & m) - ci : (x & m) + (y & m) + ci;
      nxt[0] = r[n];
      nxt[4] = x[4] ^ y[4] ^ r[4];
      nxt[11] = ((x[n-1] ^ y[n-1]) == sb) && (r[n-1] != x[n-1]);
      r = r & m;
    end else if (o == pfu_pkg::OP_LOGIC) begin
      nxt[0] = 1'b0;
      nxt[4] = 1'b0;
      nxt[11] = 1'b0;
    end
    if (sb || o inside {pfu_pkg::OP_ADD, pfu_pkg::OP_ADC,
      pfu_pkg::OP_LOGIC}) begin
      nxt[6] = (r == 65'h0);
      nxt[7] = r[n-1];
      nxt[2] = ~^r[7:0];
    end
    if (o == pfu_pkg::OP_SET_CARRY) nxt[0] = 1'b1;
    if (o == pfu_pkg::OP_CLR_CARRY) nxt[0] = 1'b0;
    if (o == pfu_pkg::OP_INV_CARRY) nxt[0] = ~f[0];
    if (o == pfu_pkg::OP_BIT_TEST) nxt[0] = bv;
    if (o == pfu_pkg::OP_SET_DIR) nxt[10] = 1'b1;
    if (o == pfu_pkg::OP_CLR_DIR) nxt[10] = 1'b0;
    if (o inside {pfu_pkg::OP_POP_FLAGS, pfu_pkg::OP_INT_RET,
      pfu_pkg::OP_LOAD}) begin
      wm = pfu_pkg::FLAGS_IMPL;
      if (priv_lvl != 2'h0) wm[13:12] = 2'h0;
      if (!ctrl_m[2]) wm[21] = 1'b0;
      nxt = (f & ~wm) | (w & wm) | 32'h2;
    end
  endfunction : nxt

  task automatic tick;
    @(posedge ref_clk);
  endtask : tick

  task automatic idle;
    issue <= 1'b0;
    rd <= 1'b0;
    wr <= 1'b0;
    tick;
  endtask : idle

  task automatic instr(input pfu_pkg::pfu_op_t o, input logic [1:0] s,
      input logic [63:0] x, y, input logic bv, input logic [31:0] w);
    ef = nxt(ef, o, s, x, y, bv, w);
    fq.push_back(ef);
    op <= o;
    size <= s;
    a <= x;
    b <= y;
    bit_val <= bv;
    img <= w;
    issue <= 1'b1;
    rd <= 1'b0;
    wr <= 1'b0;
    tick;
  endtask : instr

  task automatic reg_rd(input logic [3:0] ad, input logic [31:0] x);
    rq.push_back(x);
    addr <= ad;
    rd <= 1'b1;
    wr <= 1'b0;
    issue <= 1'b0;
    tick;
  endtask : reg_rd

  // write lands only after pending flag checks are done
  task automatic reg_wr(input logic [3:0] ad, input logic [31:0] d);
    idle;
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    tick;
    if (ad == pfu_pkg::ADDR_CTRL) ctrl_m = d & pfu_pkg::CTRL_MASK;
  endtask : reg_wr

  task automatic set_priv(input logic [1:0] v);
    idle;
    priv_lvl <= v;
    idle;
  endtask : set_priv

  task automatic task_link(input logic lk, ul, nt);
    idle;
    link_task <= lk;
    unlink_task <= ul;
    tick;
    link_task <= 1'b0;
    unlink_task <= 1'b0;
    ef[14] = nt;
    instr(pfu_pkg::OP_NONE, 2'h0, 64'h0, 64'h0, 1'b0, 32'h0);
  endtask : task_link

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // compares each result with the oldest note queued for it
  always @(posedge ref_clk) begin
    if (rd_p) begin
      e = rq.pop_front();
      `CHK("rdata", e, rdata)
    end
    if (iv_p) begin
      e = fq.pop_front();
      `CHK("flags_64", {32'h0, e}, flags_64)
      `CHK("string_dec", e[10], string_dec)
      `CHK("single_step", e[8], single_step)
      `CHK("irq_accept", e[9], irq_accept)
      `CHK("io_permit", priv_lvl <= e[13:12], io_permit)
      `CHK("debug_resume", e[16], debug_resume)
      `CHK("v86_mode", e[17], v86_mode)
      `CHK("align_check", e[18] & ctrl_m[0], align_check)
      `CHK("virt_irq_en", e[19] & ctrl_m[1], virt_irq_en)
      `CHK("virt_irq_pend", e[20] & ctrl_m[1], virt_irq_pend)
    end
    rd_p = rd;
    iv_p = issue;
  end

  // hang guard
  initial begin
    repeat (20000) tick;
    err_count++;
    report_and_stop;
  end

  initial begin
    {rst_n, init, link_task, unlink_task, wr, rd, issue, bit_val} = 8'h0;
    {rd_p, iv_p, priv_lvl, size, addr} = 10'h0;
    {wdata, img, a, b} = 192'h0;
    op = pfu_pkg::OP_NONE;
    ef = 32'h2;
    ctrl_m = pfu_pkg::CTRL_RESET;
    repeat (2) tick;
    rst_n <= 1'b1;
    reg_rd(pfu_pkg::ADDR_FLAGS_LO, 32'h2);
    reg_rd(pfu_pkg::ADDR_FLAGS_HI, 32'h0);
    reg_rd(pfu_pkg::ADDR_CTRL, pfu_pkg::CTRL_RESET);
    reg_wr(pfu_pkg::ADDR_FLAGS_LO, 32'hffff_ffff);
    reg_rd(4'hf, 32'h0);
    reg_rd(pfu_pkg::ADDR_FLAGS_LO, 32'h2);
    // arithmetic corners, carry chained back to back
    instr(pfu_pkg::OP_ADD, 2'h0, 64'hff, 64'h1, 1'b0, 32'h0);
    instr(pfu_pkg::OP_ADC, 2'h0, 64'h7f, 64'h0, 1'b0, 32'h0);
    instr(pfu_pkg::OP_SUB, 2'h3, 64'h0, 64'h1, 1'b0, 32'h0);
    instr(pfu_pkg::OP_SUB_BORROW, 2'h2, 64'h5, 64'h5, 1'b0, 32'h0);
    instr(pfu_pkg::OP_ADD, 2'h1, 64'h0, 64'h0, 1'b0, 32'h0);
    foreach (cops[i]) instr(cops[i], 2'h0, 64'h0, 64'h0, i[0], 32'h0);
    // system image loads at privilege 0, 3 and 2 under control words 4, 7 and 0
    instr(pfu_pkg::OP_POP_FLAGS, 2'h0, 64'h0, 64'h0, 1'b0,
      32'hffff_ffff);
    reg_wr(pfu_pkg::ADDR_CTRL, 32'h7);
    instr(pfu_pkg::OP_NONE, 2'h0, 64'h0, 64'h0, 1'b0, 32'h0);
    set_priv(2'h3);
    instr(pfu_pkg::OP_POP_FLAGS, 2'h0, 64'h0, 64'h0, 1'b0, 32'h0);
    instr(pfu_pkg::OP_INT_RET, 2'h0, 64'h0, 64'h0, 1'b0, 32'h1000);
    set_priv(2'h0);
    instr(pfu_pkg::OP_INT_RET, 2'h0, 64'h0, 64'h0, 1'b0, 32'h1000);
    set_priv(2'h2);
    instr(pfu_pkg::OP_LOAD, 2'h0, 64'h0, 64'h0, 1'b0, 32'h20_0000);
    reg_wr(pfu_pkg::ADDR_CTRL, 32'h0);
    instr(pfu_pkg::OP_LOAD, 2'h0, 64'h0, 64'h0, 1'b0, 32'h4_0000);
    task_link(1'b1, 1'b1, 1'b1);
    task_link(1'b0, 1'b1, 1'b0);
    // initialisation keeps the control word
    idle;
    init <= 1'b1;
    tick;
    init <= 1'b0;
    ef = 32'h2;
    reg_rd(pfu_pkg::ADDR_FLAGS_LO, 32'h2);
    reg_rd(pfu_pkg::ADDR_CTRL, ctrl_m);
    // random arithmetic at all sizes, back to back
    for (int k = 0; k < 60; k++) begin
      rs = $random(seed);
      instr(aops[rs[2:0]], rs[4:3], {$random(seed), $random(seed)},
        {$random(seed), $random(seed)}, 1'b0, 32'h0);
    end
    reg_rd(pfu_pkg::ADDR_FLAGS_LO, ef);
    idle;
    idle;
    report_and_stop;
  end
endmodule : tb_top
